// *** bench/brhp_checker.sv ***
`timescale 1ns/1ns
// ====
// pin protocol checker for the host port
module brhp_checker (
    input wire core_clk,
    input wire rst_n,
    input wire ce_n,
    input wire oe_n,
    input wire hard_reset_n,
    input wire dq_oe,
    input wire rdy,
    input wire soft_reset,
    input wire cfg_wr_en,
    input wire [15:0] cfg_wr_data,
    input wire read_mode_select,
    input wire [2:0] burst_latency_cycles,
    input wire mem_rd_req
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // five cycles covers two sync flops plus the output register
    sequence s_ce_off; ce_n[*5]; endsequence
    sequence s_cfg_wr; hard_reset_n[*4] ##0 (cfg_wr_en && !soft_reset);
    endsequence
    a_ce_tristate: assert property (s_ce_off |-> !dq_oe)
        else $error("data driven with chip enable high");
    a_oe_tristate: assert property (oe_n[*5] |-> !dq_oe)
        else $error("data driven with output enable high");
    a_ce_ends_rdy: assert property (s_ce_off |-> !rdy)
        else $error("ready seen with chip enable high");
    a_hard_defaults: assert property ((!hard_reset_n)[*5] |->
        !read_mode_select && burst_latency_cycles == 3'h4)
        else $error("reset pin left config changed");
    a_soft_defaults: assert property (soft_reset |-> ##[1:4]
        (!read_mode_select && burst_latency_cycles == 3'h4))
        else $error("soft reset left config changed");
    a_cfg_mode_bit: assert property (s_cfg_wr |=>
        read_mode_select == $past(cfg_wr_data[15]))
        else $error("mode bit not taken");
    a_lat_clamp: assert property (s_cfg_wr |=> burst_latency_cycles ==
        ($past(cfg_wr_data[14:12]) < 3'h3 ? 3'h3
        : $past(cfg_wr_data[14:12])))
        else $error("latency field wrong");
    a_rdy_pulse: assert property ($rose(rdy) |-> ##[1:40] !rdy)
        else $error("ready held too long");
    a_req_single: assert property (mem_rd_req |=> !mem_rd_req)
        else $error("memory request longer than one cycle");
endmodule // brhp_checker
bind brhp_host_port brhp_checker brhp_checker_i (.core_clk(core_clk),
    .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n), .hard_reset_n(hard_reset_n),
    .dq_oe(dq_oe), .rdy(rdy), .soft_reset(soft_reset),
    .cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data),
    .read_mode_select(read_mode_select),
    .burst_latency_cycles(burst_latency_cycles), .mem_rd_req(mem_rd_req));

// *** bench/brhp_host_port_tb.sv ***
`timescale 1ns/1ns
module brhp_host_port_tb;
    logic core_clk, rst_n, burst_clk, address_valid_n, ce_n, oe_n, we_n;
    logic hard_reset_n, soft_reset, cfg_wr_en, slow, mem_rd_valid;
    logic [15:0] addr, cfg_wr_data, mem_rd_data;
    wire [15:0] dq_out, mem_rd_addr;
    wire dq_oe, rdy, read_mode_select, mem_rd_req;
    wire [2:0] burst_latency_cycles;
    int fail_count = 0;
    int tests_run = 0;
    brhp_host_port brhp_host_port_i (.core_clk(core_clk), .rst_n(rst_n),
        .burst_clk(burst_clk), .address_valid_n(address_valid_n),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .hard_reset_n(hard_reset_n),
        .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .rdy(rdy),
        .soft_reset(soft_reset), .cfg_wr_en(cfg_wr_en),
        .cfg_wr_data(cfg_wr_data), .read_mode_select(read_mode_select),
        .burst_latency_cycles(burst_latency_cycles),
        .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
        .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));
    brhp_mem_model brhp_mem_model_i (.core_clk(core_clk), .rst_n(rst_n),
        .slow(slow), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
        .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));
    // ====
    // helpers
    task conclude;
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task cfg(input logic [15:0] w);
        @(posedge core_clk) {cfg_wr_en, cfg_wr_data} <= {1'b1, w};
        @(posedge core_clk) cfg_wr_en <= 1'b0;
    endtask
    // one host clock period of 16 core cycles; ends settled before a rise
    task rise;
        @(posedge core_clk) burst_clk <= 1'b1;
        cyc(8);
        burst_clk <= 1'b0;
        cyc(7);
        #1;
    endtask
    // address of word k of a burst; fixed lengths wrap in their group
    function logic [15:0] wrd(input logic [15:0] s, input logic [2:0] c,
        input int k);
        logic [15:0] m;
        m = (16'h0002 << c) - 16'h0001;
        return c == 3'h0 ? s + k[15:0] : (s & ~m) | ((s + k[15:0]) & m);
    endfunction
    // latch an address with strobe and one host clock edge
    task start(input logic [15:0] a);
        @(posedge core_clk) {ce_n, oe_n, address_valid_n} <= 3'b000;
        addr <= a;
        cyc(4);
        rise;
        @(posedge core_clk) address_valid_n <= 1'b1;
    endtask
    task stop;
        @(posedge core_clk) {ce_n, oe_n} <= 2'b11;
        cyc(6);
        check({14'h0, dq_oe, rdy}, 16'h0000);
    endtask
    // ====
    // scenarios
    task single(input logic [15:0] a, input logic [15:0] exp);
        start(a);
        cyc(24);
        check(dq_out, exp);
        check({15'h0, dq_oe}, 16'h0001);
        stop;
    endtask
    task burst(input logic [15:0] s, input logic [2:0] c, input logic [2:0] n);
        int j;
        cfg({1'b1, n, c, 9'h000});
        start(s);
        for (j = 1; j <= n + 6; j++) begin
            check({15'h0, rdy}, {15'h0, j == n + 1});
            if (j > n) check(dq_out, wrd(s, c, j - n - 1) ^ 16'h5a00);
            rise;
        end
        stop;
    endtask
    // write pulse mid-latency ends the burst; output enable alone tristates
    task cut;
        cfg(16'hb000);
        start(16'h0240);
        rise;
        check(dq_out, 16'h5840);
        @(posedge core_clk) we_n <= 1'b0;
        @(posedge core_clk) we_n <= 1'b1;
        repeat (3) rise;
        check(dq_out, 16'h5840);
        @(posedge core_clk) oe_n <= 1'b1;
        cyc(6);
        check({15'h0, dq_oe}, 16'h0000);
        stop;
    endtask
    // ====
    // main sequence
    initial begin
        core_clk = 0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        {rst_n, burst_clk, cfg_wr_en, soft_reset, slow} = 5'b00000;
        {address_valid_n, ce_n, oe_n, we_n, hard_reset_n} = 5'b11111;
        addr = 16'h0000;
        cfg_wr_data = 16'h0000;
        cyc(2);
        rst_n <= 1'b1;
        cyc(4);
        check({read_mode_select, burst_latency_cycles}, 16'h0004);
        single(16'h0300, 16'h5900);
        for (int i = 0; i < 5; i++) begin
            slow <= i > 2;
            burst(16'h021e, i[2:0], 3'h3 + i[2:0]);
        end
        single(16'hf221, 16'hf800);
        cut;
        @(posedge core_clk) hard_reset_n <= 1'b0;
        cyc(6);
        check({read_mode_select, burst_latency_cycles}, 16'h0004);
        hard_reset_n <= 1'b1;
        cyc(3);
        cfg(16'h9000);
        cyc(1);
        check({read_mode_select, burst_latency_cycles}, 16'h000b);
        cfg(16'hf800);
        cyc(1);
        check({read_mode_select, burst_latency_cycles}, 16'h000f);
        cyc(4);
        soft_reset <= 1'b1;
        @(posedge core_clk) soft_reset <= 1'b0;
        cyc(4);
        check({read_mode_select, burst_latency_cycles}, 16'h0004);
        conclude;
    end
    // hang guard, far beyond the roughly 1300 cycles used
    initial begin
        #100000;
        fail_count++;
        conclude;
    end
endmodule // brhp_host_port_tb

// *** bench/brhp_mem_model.sv ***
`timescale 1ns/1ns
// ====
// buffer memory behind the port; answers one read at a time
module brhp_mem_model (
    input wire core_clk,
    input wire rst_n,
    input wire slow,
    input wire mem_rd_req,
    input wire [15:0] mem_rd_addr,
    output reg mem_rd_valid,
    output reg [15:0] mem_rd_data
);
    reg [15:0] addr_reg; // captured request address
    reg [2:0] cnt_reg; // cycles left before the answer
    reg busy_reg;
    // data off the valid strobe is the inverse, never a stale copy
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            cnt_reg <= 3'h0;
            addr_reg <= 16'h0000;
            mem_rd_valid <= 1'b0;
            mem_rd_data <= 16'hffff;
        end else if (mem_rd_req) begin
            busy_reg <= 1'b1;
            addr_reg <= mem_rd_addr;
            cnt_reg <= slow ? 3'h5 : 3'h0;
            mem_rd_valid <= 1'b0;
            mem_rd_data <= ~mem_rd_data;
        end else if (busy_reg && cnt_reg == 3'h0) begin
            busy_reg <= 1'b0;
            mem_rd_valid <= 1'b1;
            mem_rd_data <= addr_reg ^ 16'h5a00;
        end else begin
            cnt_reg <= cnt_reg - 3'h1;
            mem_rd_valid <= 1'b0;
            mem_rd_data <= ~mem_rd_data;
        end
    end
endmodule // brhp_mem_model

// *** include/brhp_defines.vh ***
`ifndef BRHP_DEFINES_VH
`define BRHP_DEFINES_VH
// =====================================================================
// bus widths
`define BRHP_ADDR_W 16
`define BRHP_DATA_W 16
// =====================================================================
// synchronised pin vector layout
`define BRHP_PIN_W 22
`define BRHP_PIN_HRST 16
`define BRHP_PIN_WE 17
`define BRHP_PIN_OE 18
`define BRHP_PIN_CE 19
`define BRHP_PIN_AVD 20
`define BRHP_PIN_CLK 21
// idle level of every pin: strobes high, clock and address low
`define BRHP_PIN_IDLE 22'h1f_0000
// =====================================================================
// configuration word (system configuration 1) and its fields
`define BRHP_CFG_ADDR 16'hf221
`define BRHP_CFG_RM_BIT 15
`define BRHP_CFG_LAT_HI 14
`define BRHP_CFG_LAT_LO 12
`define BRHP_CFG_LEN_HI 11
`define BRHP_CFG_LEN_LO 9
// =====================================================================
// latency limits and default
`define BRHP_LAT_DEFAULT 3'h4
`define BRHP_LAT_MIN 3'h3
// =====================================================================
// burst length codes
`define BRHP_LEN_CONT 3'h0
`define BRHP_LEN_4 3'h1
`define BRHP_LEN_8 3'h2
`define BRHP_LEN_16 3'h3
`define BRHP_LEN_32 3'h4
`define BRHP_MASK_4 16'h0003
`define BRHP_MASK_8 16'h0007
`define BRHP_MASK_16 16'h000f
`define BRHP_MASK_32 16'h001f
// =====================================================================
// fifo shape
`define BRHP_FIFO_DEPTH 16
`define BRHP_FIFO_AW 4
`endif

// *** rtl/brhp_fifo.v ***
`timescale 1ns/1ns
// =====================================================================
// small synchronous fifo, registered read data
module brhp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire core_clk,
    input wire rst_n,
    input wire clear,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage array
    reg [AW:0] wr_ptr_reg; // extra bit unused; count_reg tells full from empty
    reg [AW:0] rd_ptr_reg;
    reg [AW:0] count_reg; // words held, incl. the one in out_data
    wire push;
    wire pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});

    // write side
    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // pointers and count; clear drops everything
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else if (clear) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // head word; bypass when writing into an empty fifo
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_data <= {WIDTH{1'b0}};
        end else if (push && (count_reg == {(AW+1){1'b0}} ||
                     (pop && count_reg == {{AW{1'b0}}, 1'b1}))) begin
            out_data <= in_data;
        end else if (pop) begin
            out_data <= mem[rd_ptr_reg[AW-1:0] + 1'b1];
        end
    end
endmodule // brhp_fifo

// *** rtl/brhp_host_port.v ***
`timescale 1ns/1ns
`include "brhp_defines.vh"
// =====================================================================
// read side of the host port: async and burst reads
//
// Overview of operation
// - reset gives async mode; config bit selects burst
// - async: address latched on valid strobe, word out
// - sync: data paced by host burst clock
// - fixed bursts 4/8/16/32 wrap inside aligned group
// - continuous burst: address plus one per edge
// - first word presented at once, ignoring latency
// - latency default four, programmable three to seven
// - n edges after latch; host samples edge n+1
// - after latency, next word on each rising edge
// - latency readable by strobe cycle at config address
// - ready pulses one clock ahead of first fetch
// - sync access in async mode still yields word
// - chip enable, resets, write pulse end burst
// - chip or output enable high tristates data
module brhp_host_port (
    core_clk,
    rst_n,
    burst_clk,
    address_valid_n,
    ce_n,
    oe_n,
    we_n,
    hard_reset_n,
    addr,
    dq_out,
    dq_oe,
    rdy,
    soft_reset,
    cfg_wr_en,
    cfg_wr_data,
    read_mode_select,
    burst_latency_cycles,
    mem_rd_req,
    mem_rd_addr,
    mem_rd_valid,
    mem_rd_data
);
    input wire core_clk; // 250 mhz core clock
    input wire rst_n; // async reset, active low
    input wire burst_clk; // host burst clock pin
    input wire address_valid_n; // address latch strobe pin
    input wire ce_n;
    input wire oe_n;
    input wire we_n;
    input wire hard_reset_n; // hardware reset pin
    input wire [`BRHP_ADDR_W-1:0] addr;
    output reg [`BRHP_DATA_W-1:0] dq_out;
    output reg dq_oe; // high while data pins are driven
    output reg rdy;
    input wire soft_reset; // cold, warm or hot reset pulse
    input wire cfg_wr_en; // write of the configuration word
    input wire [`BRHP_DATA_W-1:0] cfg_wr_data;
    output reg read_mode_select; // 1: synchronous burst
    output reg [2:0] burst_latency_cycles;
    output wire mem_rd_req; // one-cycle read request
    output wire [`BRHP_ADDR_W-1:0] mem_rd_addr;
    input wire mem_rd_valid; // read answer strobe
    input wire [`BRHP_DATA_W-1:0] mem_rd_data;

    // =================================================================
    // states
    localparam ST_IDLE = 2'h0; // no transfer
    localparam ST_ASYNC = 2'h1; // single word, strobe paced
    localparam ST_LAT = 2'h2; // burst latency counting
    localparam ST_STREAM = 2'h3; // burst words on each edge
    localparam [`BRHP_PIN_W-1:0] PIN_IDLE = `BRHP_PIN_IDLE;

    // =================================================================
    // pin synchronisers
    wire [`BRHP_PIN_W-1:0] pin_raw; // all pins as one vector
    reg [`BRHP_PIN_W-1:0] meta_reg; // first stage, read by sync only
    reg [`BRHP_PIN_W-1:0] sync_reg; // second stage, safe to use
    reg clk_prev_reg; // last burst clock level
    reg avd_prev_reg; // last strobe level
    reg we_prev_reg; // last write enable level
    reg [2:0] burst_len_reg; // burst length code

    assign pin_raw = {burst_clk, address_valid_n, ce_n, oe_n, we_n,
                      hard_reset_n, addr};

    // two flops per pin bit; pins are asynchronous to core_clk
    genvar gi;
    generate
        for (gi = 0; gi < `BRHP_PIN_W; gi = gi + 1) begin : g_sync
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_reg[gi] <= PIN_IDLE[gi];
                    sync_reg[gi] <= PIN_IDLE[gi];
                end else begin
                    meta_reg[gi] <= pin_raw[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    wire clk_s = sync_reg[`BRHP_PIN_CLK];
    wire avd_s = sync_reg[`BRHP_PIN_AVD];
    wire ce_s = sync_reg[`BRHP_PIN_CE];
    wire oe_s = sync_reg[`BRHP_PIN_OE];
    wire we_s = sync_reg[`BRHP_PIN_WE];
    wire hrst_s = sync_reg[`BRHP_PIN_HRST];
    wire [`BRHP_ADDR_W-1:0] addr_s = sync_reg[`BRHP_ADDR_W-1:0];

    // edge history, taken from the second stage only
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_reg <= 1'b0;
            avd_prev_reg <= 1'b1;
            we_prev_reg <= 1'b1;
        end else begin
            clk_prev_reg <= clk_s;
            avd_prev_reg <= avd_s;
            we_prev_reg <= we_s;
        end
    end

    wire clk_rise = clk_s && !clk_prev_reg;
    wire avd_fall = !avd_s && avd_prev_reg;
    wire we_fall = !we_s && we_prev_reg;
    // a read cycle: chip selected, write enable high
    wire rd_sel = !ce_s && we_s;

    // =================================================================
    // configuration: mode, latency, length
    wire any_reset = soft_reset || !hrst_s;
    wire [2:0] cfg_lat_in = cfg_wr_data[`BRHP_CFG_LAT_HI:`BRHP_CFG_LAT_LO];

    // reset values give async mode and four clocks of latency
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            read_mode_select <= 1'b0;
            burst_latency_cycles <= `BRHP_LAT_DEFAULT;
            burst_len_reg <= `BRHP_LEN_CONT;
        end else if (any_reset) begin
            read_mode_select <= 1'b0;
            burst_latency_cycles <= `BRHP_LAT_DEFAULT;
            burst_len_reg <= `BRHP_LEN_CONT;
        end else if (cfg_wr_en) begin
            read_mode_select <= cfg_wr_data[`BRHP_CFG_RM_BIT];
            // values under three are raised to the minimum
            burst_latency_cycles <= (cfg_lat_in < `BRHP_LAT_MIN) ?
                `BRHP_LAT_MIN : cfg_lat_in;
            burst_len_reg <= cfg_wr_data[`BRHP_CFG_LEN_HI:`BRHP_CFG_LEN_LO];
        end
    end

    // configuration word as read back by the host
    wire [`BRHP_DATA_W-1:0] cfg_word = {read_mode_select,
        burst_latency_cycles, burst_len_reg, 9'h000};

    // wrap mask of the selected fixed burst length
    reg [`BRHP_ADDR_W-1:0] wrap_mask;
    always @* begin
        case (burst_len_reg)
            `BRHP_LEN_4: wrap_mask = `BRHP_MASK_4;
            `BRHP_LEN_8: wrap_mask = `BRHP_MASK_8;
            `BRHP_LEN_16: wrap_mask = `BRHP_MASK_16;
            `BRHP_LEN_32: wrap_mask = `BRHP_MASK_32;
            default: wrap_mask = {`BRHP_ADDR_W{1'b1}}; // continuous
        endcase
    end

    // =================================================================
    // control state machine
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [2:0] lat_cnt_reg; // edges since the latching edge
    reg [2:0] lat_cnt_next;
    reg first_shown_reg; // first word already on the pins
    reg first_shown_next;
    reg rdy_next;
    reg start; // begin fetching at the latched address
    reg start_single; // fetch one word only
    reg abort; // drop the transfer and flush

    // fifo hookup
    wire fifo_in_valid;
    wire fifo_in_ready;
    wire [`BRHP_DATA_W-1:0] fifo_in_data;
    wire fifo_out_valid;
    reg fifo_pop;
    wire [`BRHP_DATA_W-1:0] fifo_out_data;

    // burst termination: chip enable high, either reset, write pulse
    wire burst_end = ce_s || any_reset || we_fall;

    // next state and the word pop per clock edge
    always @* begin
        state_next = state_reg;
        lat_cnt_next = lat_cnt_reg;
        first_shown_next = first_shown_reg;
        rdy_next = 1'b0;
        start = 1'b0;
        start_single = 1'b0;
        abort = 1'b0;
        fifo_pop = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (rd_sel && !any_reset) begin
                    if (read_mode_select && !avd_s && clk_rise) begin
                        // address taken on the clock edge
                        start = 1'b1;
                        state_next = ST_LAT;
                    end else if (avd_fall && !read_mode_select) begin
                        // strobe paced, also when the host clocks
                        // while the mode is still asynchronous
                        start = 1'b1;
                        start_single = 1'b1;
                        state_next = ST_ASYNC;
                    end
                end
                lat_cnt_next = 3'h0;
                first_shown_next = 1'b0;
            end
            ST_ASYNC: begin
                if (!first_shown_reg && fifo_out_valid) begin
                    fifo_pop = 1'b1;
                    first_shown_next = 1'b1;
                end
                if (ce_s || any_reset || !we_s) begin
                    abort = 1'b1;
                    state_next = ST_IDLE;
                end else if (avd_fall) begin
                    // a new address only ends the access; back in ST_IDLE no strobe fall is seen, so no new one starts
                    abort = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_LAT: begin
                // first word goes out as soon as it exists
                if (!first_shown_reg && fifo_out_valid) begin
                    fifo_pop = 1'b1;
                    first_shown_next = 1'b1;
                end
                if (clk_rise) begin
                    lat_cnt_next = lat_cnt_reg + 3'h1;
                end
                // ready rises one host clock ahead of the fetch edge
                rdy_next = (lat_cnt_next == burst_latency_cycles);
                if (clk_rise && lat_cnt_reg == burst_latency_cycles) begin
                    // edge n+1: host samples the first word here
                    rdy_next = 1'b0;
                    state_next = ST_STREAM;
                    // the same edge already moves on to the second word
                    if (first_shown_reg && fifo_out_valid) begin
                        fifo_pop = 1'b1;
                    end
                end
                if (burst_end) begin
                    abort = 1'b1;
                    rdy_next = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            ST_STREAM: begin
                // each later edge moves to the next word
                if (clk_rise && fifo_out_valid) begin
                    fifo_pop = 1'b1;
                end
                if (burst_end) begin
                    abort = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                abort = 1'b1;
                state_next = ST_IDLE;
            end
        endcase
    end

    // state registers
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            lat_cnt_reg <= 3'h0;
            first_shown_reg <= 1'b0;
            rdy <= 1'b0;
        end else begin
            state_reg <= state_next;
            lat_cnt_reg <= lat_cnt_next;
            first_shown_reg <= first_shown_next;
            rdy <= rdy_next;
        end
    end

    // =================================================================
    // fetcher: one read outstanding, stalled by fifo back-pressure
    reg [`BRHP_ADDR_W-1:0] fetch_addr_reg;
    reg [5:0] fetch_left_reg; // words still to fetch
    reg fetch_on_reg; // fetching enabled
    reg fetch_cont_reg; // no word limit
    reg pend_reg; // a memory read is in flight
    reg cfg_push_reg; // pending config readback word
    wire start_cfg = start && (addr_s == `BRHP_CFG_ADDR);
    wire fetch_more = fetch_cont_reg || (fetch_left_reg != 6'h00);

    // stale answers after an abort are ignored via pend_reg; the
    // memory must answer before the next strobe can arrive
    assign mem_rd_req = fetch_on_reg && !pend_reg && !cfg_push_reg &&
                        fetch_more && fifo_in_ready;
    assign mem_rd_addr = fetch_addr_reg;
    assign fifo_in_valid = (mem_rd_valid && pend_reg) || cfg_push_reg;
    assign fifo_in_data = cfg_push_reg ? cfg_word : mem_rd_data;

    // address walk: linear, or wrapping inside the aligned group
    wire [`BRHP_ADDR_W-1:0] addr_inc = fetch_addr_reg + 16'h0001;
    wire [`BRHP_ADDR_W-1:0] addr_wrap =
        (fetch_addr_reg & ~wrap_mask) | (addr_inc & wrap_mask);

    // words per fixed burst; the host ends it with chip enable
    reg [5:0] burst_words;
    always @* begin
        case (burst_len_reg)
            `BRHP_LEN_4: burst_words = 6'h04;
            `BRHP_LEN_8: burst_words = 6'h08;
            `BRHP_LEN_16: burst_words = 6'h10;
            `BRHP_LEN_32: burst_words = 6'h20;
            default: burst_words = 6'h00;
        endcase
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr_reg <= {`BRHP_ADDR_W{1'b0}};
            fetch_left_reg <= 6'h00;
            fetch_on_reg <= 1'b0;
            fetch_cont_reg <= 1'b0;
            pend_reg <= 1'b0;
            cfg_push_reg <= 1'b0;
        end else if (abort) begin
            fetch_on_reg <= 1'b0;
            pend_reg <= 1'b0;
            cfg_push_reg <= 1'b0;
        end else if (start) begin
            fetch_addr_reg <= addr_s;
            // config readback is a single word in either mode
            cfg_push_reg <= start_cfg;
            fetch_on_reg <= !start_cfg;
            fetch_cont_reg <= !start_single &&
                              (burst_len_reg == `BRHP_LEN_CONT);
            fetch_left_reg <= start_single ? 6'h01 : burst_words;
        end else begin
            if (cfg_push_reg && fifo_in_ready) begin
                cfg_push_reg <= 1'b0;
            end
            if (mem_rd_req) begin
                pend_reg <= 1'b1;
                fetch_addr_reg <= addr_wrap;
                if (!fetch_cont_reg) begin
                    fetch_left_reg <= fetch_left_reg - 6'h01;
                end
            end else if (mem_rd_valid) begin
                pend_reg <= 1'b0;
            end
            // fixed burst wraps again until the host stops it
            if (!fetch_cont_reg && !fetch_more && !start_single &&
                state_reg != ST_ASYNC) begin
                fetch_left_reg <= burst_words;
            end
        end
    end

    // =================================================================
    // fifo between memory fetch and pin output
    brhp_fifo #(
        .WIDTH(`BRHP_DATA_W),
        .DEPTH(`BRHP_FIFO_DEPTH),
        .AW(`BRHP_FIFO_AW)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(abort),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // =================================================================
    // data pins; the head word is taken at the pop, since the fifo
    // moves its output register to the next word on that same edge
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_out <= {`BRHP_DATA_W{1'b0}};
            dq_oe <= 1'b0;
        end else begin
            if (fifo_pop) begin
                dq_out <= fifo_out_data;
            end
            // drive only with both enables low and not writing
            dq_oe <= !ce_s && !oe_s && we_s && hrst_s;
        end
    end
endmodule // brhp_host_port
